// >>> hw/spd_pkg.sv
// Shared constants, types and helpers of the synthesizer output post-divider block.
package spd_pkg;

    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_A0 = 8'h8C;
    localparam logic [7:0] IDX_B0 = 8'h8F;
    localparam logic [7:0] IDX_STATUS = 8'hA0;
    localparam logic [23:0] CFG_RST = 24'h00_0002;
    localparam logic [23:0] CNT_RST = 24'hFF_FFFF;
    localparam logic [23:0] MIN_RATIO = 24'h00_0002;
    localparam logic [15:0] MIN_RATE = 16'h0001;
    localparam logic [3:0] MODE_FRAME = 4'hF;
    localparam logic [1:0] LF_SRC_A = 2'h0;
    localparam logic [1:0] LF_SRC_B = 2'h1;
    localparam logic [2:0] BYTES_ALL = 3'h7;

    typedef enum logic [1:0] {
        SPD_DIV = 2'b00,
        SPD_LOWF = 2'b01,
        SPD_FRAME = 2'b10
    } spd_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } spd_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } spd_apb_rsp_t;

    typedef struct packed {
        logic out_b;
        logic out_a;
        logic [2:0] pend_b;
        logic [2:0] pend_a;
        spd_mode_t mode_b;
        spd_mode_t mode_a;
    } spd_status_t;

    typedef struct packed {
        logic [23:0] cnt;
        logic [15:0] edge_cnt;
        logic [3:0] src_prev;
        logic pulse;
        logic out;
    } spd_div_state_t;

    typedef struct packed {
        logic [23:0] cfg_a;
        logic [23:0] cfg_b;
        logic [23:0] stage_a;
        logic [23:0] stage_b;
        logic [2:0] mask_a;
        logic [2:0] mask_b;
        logic load_a;
        logic load_b;
        logic [31:0] prdata;
        logic pslverr;
        logic seen_b;
    } spd_regs_t;

    // Byte address of a register index: each index takes one aligned word.
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // Output kind selected by a configuration word.
    function automatic spd_mode_t cfg_mode(input logic [23:0] cfg, input logic [1:0] lf_src);
        if (cfg[23:20] != MODE_FRAME) begin
            return SPD_DIV;
        end else if (cfg[17:16] == lf_src) begin
            return SPD_LOWF;
        end else begin
            return SPD_FRAME;
        end
    endfunction

endpackage

// >>> hw/spd_post_div.sv
// One output post-divider: plain divider, low-frequency clock or frame pulse generator.
`timescale 1ns/1ps
module spd_post_div #(
    parameter logic [1:0] LF_SRC = 2'h1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [23:0] cfg,
    input wire logic load,
    input wire logic tick,
    input wire logic [3:0] src,
    output logic out
);
    spd_pkg::spd_div_state_t st_reg;
    spd_pkg::spd_div_state_t st_next;
    spd_pkg::spd_mode_t mode;
    logic [23:0] ratio;
    logic [23:0] lf_div;
    logic [15:0] rate;
    logic cur;
    logic prev;
    logic rise_sel;
    logic fall_sel;
    logic edge_sel;

    // Ratios below two cannot make a 50% clock, so they run as two.
    function automatic logic [23:0] clamp2(input logic [23:0] n);
        return (n < spd_pkg::MIN_RATIO) ? spd_pkg::MIN_RATIO : n;
    endfunction

    // Count of high steps in one period of n steps.
    function automatic logic [23:0] hi_len(input logic [23:0] n);
        return 24'((25'(n) + 25'd1) >> 1);
    endfunction

    always_comb begin
        mode = spd_pkg::cfg_mode(cfg, LF_SRC);
        ratio = clamp2(cfg);
        lf_div = clamp2({8'h00, cfg[15:0]});
        rate = (cfg[15:0] == 16'h0000) ? spd_pkg::MIN_RATE : cfg[15:0];
        cur = src[cfg[17:16]];
        prev = st_reg.src_prev[cfg[17:16]];
        rise_sel = cur & ~prev;
        fall_sel = ~cur & prev;
        edge_sel = cfg[19] ? rise_sel : fall_sel;
        st_next = st_reg;
        st_next.src_prev = src;
        case (mode)
            spd_pkg::SPD_DIV: begin
                st_next.pulse = 1'b0;
                st_next.edge_cnt = 16'h0000;
                st_next.cnt = (st_reg.cnt >= ratio - 24'h00_0001) ? 24'h00_0000 : st_reg.cnt + 24'h00_0001;
                st_next.out = st_next.cnt < hi_len(ratio);
            end
            spd_pkg::SPD_LOWF: begin
                st_next.pulse = 1'b0;
                if (tick) begin
                    st_next.cnt = (st_reg.cnt >= lf_div - 24'h00_0001) ? 24'h00_0000 : st_reg.cnt + 24'h00_0001;
                    st_next.out = st_next.cnt < hi_len(lf_div);
                end
            end
            spd_pkg::SPD_FRAME: begin
                if (edge_sel) begin
                    if (st_reg.edge_cnt >= rate - 16'h0001) begin
                        st_next.edge_cnt = 16'h0000;
                        st_next.pulse = 1'b1;
                    end else begin
                        st_next.edge_cnt = st_reg.edge_cnt + 16'h0001;
                        st_next.pulse = 1'b0;
                    end
                end
                st_next.out = st_next.pulse ^ cfg[18];
            end
            default: begin
                st_next.out = 1'b0;
            end
        endcase
        if (load) begin
            st_next.cnt = 24'h00_0000;
            st_next.edge_cnt = 16'h0000;
            st_next.pulse = 1'b0;
            st_next.out = (mode == spd_pkg::SPD_FRAME) ? cfg[18] : 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // The counter starts at its top so the first edge after reset wraps and drives the output high.
            st_reg <= '0;
            st_reg.cnt <= spd_pkg::CNT_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign out = st_reg.out;

    sequence s_div_two;
        mode == spd_pkg::SPD_DIV && ratio == spd_pkg::MIN_RATIO && !load;
    endsequence

    AST_DIV_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
        s_div_two ##1 s_div_two |=> out != $past(out))
        else $error("Divide-by-two output failed to toggle.");

    AST_DIV_WRAP_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        mode == spd_pkg::SPD_DIV && !load && st_reg.cnt == ratio - 24'h00_0001 |=> out)
        else $error("Divider output not high at start of period.");

    AST_LF_STILL: assert property (@(posedge clk) disable iff (!rst_n)
        mode == spd_pkg::SPD_LOWF && !tick && !load |=> $stable(out))
        else $error("Low-frequency output moved without a base tick.");

    AST_FRAME_SPACE: assert property (@(posedge clk) disable iff (!rst_n)
        mode == spd_pkg::SPD_FRAME && !load && edge_sel && st_reg.edge_cnt >= rate - 16'h0001 |=> st_reg.pulse)
        else $error("Frame pulse missing after the programmed count.");

    AST_FRAME_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
        mode == spd_pkg::SPD_FRAME && !load && st_reg.pulse && !edge_sel |=> st_reg.pulse)
        else $error("Frame pulse ended before a full source period.");

    AST_FRAME_POL: assert property (@(posedge clk) disable iff (!rst_n)
        mode == spd_pkg::SPD_FRAME && !load |=> out == (st_reg.pulse ^ $past(cfg[18])))
        else $error("Frame pulse polarity wrong.");

    AST_FRAME_FMT: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(st_reg.pulse) && $past(mode == spd_pkg::SPD_FRAME) |-> $past(cfg[19] ? rise_sel : fall_sel))
        else $error("Frame pulse started on the wrong source edge.");

endmodule // spd_post_div

// >>> hw/spd_post_divider_framer.sv
// Output post-dividers A and B of the second synthesizer with their APB register file.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module spd_post_divider_framer (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire spd_pkg::spd_apb_req_t APB_REQ,
    output spd_pkg::spd_apb_rsp_t APB_RSP,
    input wire logic BASE_TICK,
    input wire logic POST_DIV_C_CLK,
    input wire logic POST_DIV_D_CLK,
    output logic OUT_A,
    output logic OUT_B
);
    spd_pkg::spd_regs_t st_reg;
    spd_pkg::spd_regs_t st_next;
    spd_pkg::spd_status_t status;
    logic setup;
    logic access;
    logic [2:0] hit_a;
    logic [2:0] hit_b;
    logic hit_stat;
    logic wr_ok;
    logic [2:0] full_a;
    logic [2:0] full_b;
    logic out_a;
    logic out_b;
    logic [3:0] src_a;
    logic [3:0] src_b;

    // One-hot byte lanes of a three-byte register starting at a given index.
    function automatic logic [2:0] byte_hits(
        input logic [spd_pkg::ADDR_W-1:0] a,
        input logic [7:0] base
    );
        logic [2:0] h;
        h = 3'h0;
        for (int k = 0; k < 3; k++) begin
            h[k] = (a == spd_pkg::reg_addr(8'(base + 8'(k))));
        end
        return h;
    endfunction

    // Picks the byte of a word named by a one-hot lane.
    function automatic logic [7:0] get_byte(input logic [23:0] w, input logic [2:0] hit);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < 3; k++) begin
            if (hit[k]) begin
                r = w[8*k +: 8];
            end
        end
        return r;
    endfunction

    // Replaces the byte of a word named by a one-hot lane.
    function automatic logic [23:0] put_byte(
        input logic [23:0] w,
        input logic [2:0] hit,
        input logic [7:0] d
    );
        logic [23:0] r;
        r = w;
        for (int k = 0; k < 3; k++) begin
            if (hit[k]) begin
                r[8*k +: 8] = d;
            end
        end
        return r;
    endfunction

    always_comb begin
        setup = APB_REQ.psel && !APB_REQ.penable;
        access = APB_REQ.psel && APB_REQ.penable;
        hit_a = byte_hits(APB_REQ.paddr, spd_pkg::IDX_A0);
        hit_b = byte_hits(APB_REQ.paddr, spd_pkg::IDX_B0);
        hit_stat = APB_REQ.paddr == spd_pkg::reg_addr(spd_pkg::IDX_STATUS);
        wr_ok = access && APB_REQ.pwrite && !st_reg.pslverr;
        full_a = st_reg.mask_a | hit_a;
        full_b = st_reg.mask_b | hit_b;
    end

    always_comb begin
        status.out_b = out_b;
        status.out_a = out_a;
        status.pend_b = st_reg.mask_b;
        status.pend_a = st_reg.mask_a;
        status.mode_b = spd_pkg::cfg_mode(st_reg.cfg_b, spd_pkg::LF_SRC_B);
        status.mode_a = spd_pkg::cfg_mode(st_reg.cfg_a, spd_pkg::LF_SRC_A);
    end

    // Read data and the error answer are decided in the setup cycle, so the
    // access phase always completes at once with data from flip-flops.
    always_comb begin
        st_next = st_reg;
        st_next.load_a = 1'b0;
        st_next.load_b = 1'b0;
        if (setup) begin
            st_next.prdata = 32'h0000_0000;
            st_next.pslverr = 1'b0;
            if (|hit_a) begin
                st_next.prdata = {24'h00_0000, get_byte(st_reg.stage_a, hit_a)};
            end else if (|hit_b) begin
                st_next.prdata = {24'h00_0000, get_byte(st_reg.stage_b, hit_b)};
            end else if (hit_stat) begin
                st_next.prdata = 32'(status);
                st_next.pslverr = APB_REQ.pwrite;
            end else begin
                st_next.pslverr = 1'b1;
            end
        end
        if (wr_ok && (|hit_a)) begin
            st_next.stage_a = put_byte(st_reg.stage_a, hit_a, APB_REQ.pwdata[7:0]);
            if (full_a == spd_pkg::BYTES_ALL) begin
                st_next.cfg_a = st_next.stage_a;
                st_next.mask_a = 3'h0;
                st_next.load_a = 1'b1;
            end else begin
                st_next.mask_a = full_a;
            end
        end
        if (wr_ok && (|hit_b)) begin
            st_next.stage_b = put_byte(st_reg.stage_b, hit_b, APB_REQ.pwdata[7:0]);
            if (full_b == spd_pkg::BYTES_ALL) begin
                st_next.cfg_b = st_next.stage_b;
                st_next.mask_b = 3'h0;
                st_next.load_b = 1'b1;
                st_next.seen_b = 1'b1;
            end else begin
                st_next.mask_b = full_b;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_reg <= '0;
            st_reg.cfg_a <= spd_pkg::CFG_RST;
            st_reg.stage_a <= spd_pkg::CFG_RST;
            st_reg.cfg_b <= spd_pkg::CFG_RST;
            st_reg.stage_b <= spd_pkg::CFG_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        APB_RSP.prdata = st_reg.prdata;
        APB_RSP.pready = access;
        APB_RSP.pslverr = access && st_reg.pslverr;
    end

    // Frame sources of A: 01 is B, 10 is C, 11 is D; 00 is its own low clock.
    assign src_a = {POST_DIV_D_CLK, POST_DIV_C_CLK, out_b, 1'b0};
    // Frame sources of B: 00 is A, 10 is C, 11 is D; 01 is its own low clock.
    assign src_b = {POST_DIV_D_CLK, POST_DIV_C_CLK, 1'b0, out_a};

    spd_post_div #(
        .LF_SRC(spd_pkg::LF_SRC_A)
    ) u_div_a (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .cfg(st_reg.cfg_a),
        .load(st_reg.load_a),
        .tick(BASE_TICK),
        .src(src_a),
        .out(out_a)
    );

    spd_post_div #(
        .LF_SRC(spd_pkg::LF_SRC_B)
    ) u_div_b (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .cfg(st_reg.cfg_b),
        .load(st_reg.load_b),
        .tick(BASE_TICK),
        .src(src_b),
        .out(out_b)
    );

    assign OUT_A = out_a;
    assign OUT_B = out_b;

    sequence s_setup_read_b;
        setup && !APB_REQ.pwrite && (|hit_b);
    endsequence

    sequence s_access_done;
        access;
    endsequence

    AST_RESET_CFG: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !st_reg.seen_b |-> st_reg.cfg_b == spd_pkg::CFG_RST)
        else $error("B word left its reset value without a full write.");

    AST_RESET_MODE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !st_reg.seen_b |-> status.mode_b == spd_pkg::SPD_DIV)
        else $error("B not in divider mode after reset.");

    AST_COMMIT_FULL: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        $changed(st_reg.cfg_b) |-> $past(wr_ok && (|hit_b) && full_b == spd_pkg::BYTES_ALL))
        else $error("B word changed without all three bytes written.");

    AST_PARTIAL_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        wr_ok && (|hit_b) && full_b != spd_pkg::BYTES_ALL |=> $stable(st_reg.cfg_b) && !st_reg.load_b)
        else $error("Partial B write reached the divider.");

    AST_LOAD_WITH_CFG: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        $changed(st_reg.cfg_b) |-> st_reg.load_b)
        else $error("B divider not restarted with its new word.");

    AST_READ_BYTE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        s_setup_read_b ##1 s_access_done |-> APB_RSP.prdata[7:0] == $past(get_byte(st_reg.stage_b, hit_b)))
        else $error("Read of a B byte returned wrong data.");

    AST_UNMAPPED_ERR: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        setup && !(|hit_a) && !(|hit_b) && !hit_stat ##1 access |-> APB_RSP.pslverr && APB_RSP.pready)
        else $error("Unmapped access not answered with an error.");

    AST_B_SRC_A: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        status.mode_b == spd_pkg::SPD_FRAME && st_reg.cfg_b[17:16] == 2'h0 && !st_reg.load_b
        && out_a == $past(out_a) |=> $stable(out_b))
        else $error("B frame output moved without an edge of post-divider A.");

    AST_A_LOWF: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        st_reg.cfg_a[23:20] == spd_pkg::MODE_FRAME && st_reg.cfg_a[17:16] == 2'h0
        |-> status.mode_a == spd_pkg::SPD_LOWF)
        else $error("A source 00 did not select the low-frequency clock.");

    sequence s_setup_read_a;
        setup && !APB_REQ.pwrite && (|hit_a);
    endsequence

    sequence s_setup_mapped;
        setup && ((|hit_a) || (|hit_b));
    endsequence

    sequence s_setup_stat_write;
        setup && APB_REQ.pwrite && hit_stat;
    endsequence

    sequence s_write_a;
        wr_ok && (|hit_a);
    endsequence

    sequence s_write_b;
        wr_ok && (|hit_b);
    endsequence

    AST_READ_A_BYTE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        s_setup_read_a ##1 s_access_done
        |-> APB_RSP.prdata == {24'h00_0000, $past(get_byte(st_reg.stage_a, hit_a))})
        else $error("Read of an A byte returned wrong data.");

    AST_READ_HIGH_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        s_setup_read_b ##1 s_access_done
        |-> APB_RSP.prdata[31:8] == 24'h00_0000)
        else $error("Read of a B byte returned nonzero upper bits.");

    AST_MAPPED_OK: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        s_setup_mapped ##1 s_access_done
        |-> APB_RSP.pready && !APB_RSP.pslverr)
        else $error("Mapped access answered with an error.");

    AST_STATUS_WRITE_ERR: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        s_setup_stat_write ##1 s_access_done
        |-> APB_RSP.pslverr)
        else $error("Write to the status register not refused.");

    AST_STAGE_A_BYTE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        s_write_a
        |=> get_byte(st_reg.stage_a, $past(hit_a)) == $past(APB_REQ.pwdata[7:0]))
        else $error("A byte write did not reach the staging word.");

    AST_STAGE_B_BYTE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        s_write_b
        |=> get_byte(st_reg.stage_b, $past(hit_b)) == $past(APB_REQ.pwdata[7:0]))
        else $error("B byte write did not reach the staging word.");

    AST_COMMIT_A_FULL: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        $changed(st_reg.cfg_a)
        |-> $past(wr_ok && (|hit_a) && full_a == spd_pkg::BYTES_ALL))
        else $error("A word changed without all three bytes written.");

    AST_PARTIAL_HOLD_A: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        wr_ok && (|hit_a) && full_a != spd_pkg::BYTES_ALL
        |=> $stable(st_reg.cfg_a) && !st_reg.load_a)
        else $error("Partial A write reached the divider.");

    AST_LOAD_WITH_CFG_A: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        $changed(st_reg.cfg_a)
        |-> st_reg.load_a)
        else $error("A divider not restarted with its new word.");

    AST_COMMIT_A_VALUE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        wr_ok && (|hit_a) && full_a == spd_pkg::BYTES_ALL
        |=> st_reg.cfg_a == st_reg.stage_a && st_reg.mask_a == 3'h0 && st_reg.load_a)
        else $error("Completed A word not applied.");

    AST_COMMIT_B_VALUE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        wr_ok && (|hit_b) && full_b == spd_pkg::BYTES_ALL
        |=> st_reg.cfg_b == st_reg.stage_b && st_reg.mask_b == 3'h0 && st_reg.load_b)
        else $error("Completed B word not applied.");

    AST_A_SRC_B: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        status.mode_a == spd_pkg::SPD_FRAME && st_reg.cfg_a[17:16] == 2'h1 && !st_reg.load_a
        && out_b == $past(out_b) |=> $stable(out_a))
        else $error("A frame output moved without an edge of post-divider B.");

    AST_B_SRC_C: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        status.mode_b == spd_pkg::SPD_FRAME && st_reg.cfg_b[17:16] == 2'h2 && !st_reg.load_b
        && POST_DIV_C_CLK == $past(POST_DIV_C_CLK) |=> $stable(out_b))
        else $error("B frame output moved without an edge of post-divider C.");

    AST_B_SRC_D: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        status.mode_b == spd_pkg::SPD_FRAME && st_reg.cfg_b[17:16] == 2'h3 && !st_reg.load_b
        && POST_DIV_D_CLK == $past(POST_DIV_D_CLK) |=> $stable(out_b))
        else $error("B frame output moved without an edge of post-divider D.");

    AST_B_LOWF: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        st_reg.cfg_b[23:20] == spd_pkg::MODE_FRAME && st_reg.cfg_b[17:16] == 2'h1
        |-> status.mode_b == spd_pkg::SPD_LOWF)
        else $error("B source 01 did not select the low-frequency clock.");

    AST_B_DIV_KIND: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        st_reg.cfg_b[23:20] != spd_pkg::MODE_FRAME
        |-> status.mode_b == spd_pkg::SPD_DIV)
        else $error("B not in divider mode for a non-frame nibble.");

    AST_A_FRAME_KIND: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        st_reg.cfg_a[23:20] == spd_pkg::MODE_FRAME && st_reg.cfg_a[17:16] != 2'h0
        |-> status.mode_a == spd_pkg::SPD_FRAME)
        else $error("A source other than 00 did not select frame pulses.");

endmodule // spd_post_divider_framer

// >>> testbench/spd_post_divider_framer_tb.sv
// Self-checking testbench of the synthesizer output post-divider block.
`timescale 1ns/1ps
module spd_post_divider_framer_tb;
    localparam logic [23:0] FRM_CFG [5] = '{24'hFA_0003, 24'hFB_0003, 24'hFE_0003, 24'hF3_0004, 24'hF8_0005};
    localparam int FRM_HI [5] = '{8, 6, 16, 6, 2};
    localparam int FRM_PER [5] = '{24, 18, 24, 24, 10};

    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    spd_pkg::spd_apb_req_t apb_req = '0;
    spd_pkg::spd_apb_rsp_t apb_rsp;
    logic base_tick = 1'b0;
    logic c_clk = 1'b0;
    logic d_clk = 1'b0;
    logic out_a;
    logic out_b;
    int err_count = 0;
    int comparisons = 0;
    int tick_cnt = 0;
    logic [31:0] rd;
    logic err;
    int hi;
    int per;

    always #12.5 sys_clk = ~sys_clk;

    // Side sources: base tick every 3 cycles, C clock period 8 cycles, D clock period 6 cycles.
    always @(posedge sys_clk) begin
        tick_cnt <= tick_cnt + 1;
        base_tick <= (tick_cnt % 3 == 2);
        if (tick_cnt % 4 == 3) begin
            c_clk <= ~c_clk;
        end
        if (tick_cnt % 3 == 2) begin
            d_clk <= ~d_clk;
        end
    end

    spd_post_divider_framer spd_post_divider_framer_inst (
        .SYS_CLK(sys_clk),
        .RESET_N(reset_n),
        .APB_REQ(apb_req),
        .APB_RSP(apb_rsp),
        .BASE_TICK(base_tick),
        .POST_DIV_C_CLK(c_clk),
        .POST_DIV_D_CLK(d_clk),
        .OUT_A(out_a),
        .OUT_B(out_b)
    );

    task automatic finish_test();
        $display("Comparisons made: %0d, mismatches: %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb_xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                            output logic [31:0] rdata, output logic rerr);
        int n;
        n = 0;
        @(posedge sys_clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= {2'b00, idx, 2'b00};
        apb_req.pwdata <= wd;
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        @(posedge sys_clk);
        while (apb_rsp.pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        if (n >= 50) begin
            err_count++;
            $display("[FAIL] pready expected 1 seen %b", apb_rsp.pready);
        end
        rdata = apb_rsp.prdata;
        rerr = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb_xfer(1'b1, idx, {24'h00_0000, d}, rd, err);
        check("write error flag", 32'h0000_0000, {31'h0000_0000, err});
    endtask

    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        apb_xfer(1'b0, idx, 32'h0000_0000, rd, err);
        check(name, exp, rd);
    endtask

    task automatic wr_cfg(input logic [7:0] base, input logic [23:0] w);
        wr(base, w[7:0]);
        wr(base + 8'h01, w[15:8]);
        wr(base + 8'h02, w[23:16]);
    endtask

    function automatic logic pick(input logic sel);
        return sel ? out_b : out_a;
    endfunction

    // The first cycle after a change may be partial, so the third full cycle is the one measured.
    task automatic shape_chk(input logic sel, input int eh, input int ep);
        for (int k = 0; k < 2; k++) begin
            hi = 0;
            per = 0;
            while (pick(sel) !== 1'b0 && per < 3000) begin
                @(negedge sys_clk);
                per++;
            end
            while (pick(sel) !== 1'b1 && per < 3000) begin
                @(negedge sys_clk);
                per++;
            end
            while (pick(sel) === 1'b1 && hi < 3000) begin
                @(negedge sys_clk);
                hi++;
            end
            per = hi;
            while (pick(sel) === 1'b0 && per < 3000) begin
                @(negedge sys_clk);
                per++;
            end
        end
        check("output high cycles", eh, hi);
        check("output period cycles", ep, per);
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        err_count++;
        $display("[FAIL] run length expected done seen timeout");
        finish_test();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd_chk("B byte 0", spd_pkg::IDX_B0, 32'h0000_0002);
        rd_chk("B byte 1", spd_pkg::IDX_B0 + 8'h01, 32'h0000_0000);
        rd_chk("B byte 2", spd_pkg::IDX_B0 + 8'h02, 32'h0000_0000);
        rd_chk("A byte 0", spd_pkg::IDX_A0, 32'h0000_0002);
        shape_chk(1'b1, 1, 2);
        // Two of three bytes staged: the running ratio must not change yet.
        wr(spd_pkg::IDX_B0 + 8'h02, 8'h00);
        wr(spd_pkg::IDX_B0, 8'h05);
        shape_chk(1'b1, 1, 2);
        wr(spd_pkg::IDX_B0 + 8'h01, 8'h00);
        shape_chk(1'b1, 3, 5);
        wr_cfg(spd_pkg::IDX_B0, 24'h00_0006);
        shape_chk(1'b1, 3, 6);
        apb_xfer(1'b0, 8'h10, 32'h0000_0000, rd, err);
        check("unmapped read error", 32'h0000_0001, {31'h0000_0000, err});
        check("unmapped read data", 32'h0000_0000, rd);
        apb_xfer(1'b1, spd_pkg::IDX_STATUS, 32'h0000_00FF, rd, err);
        check("status write error", 32'h0000_0001, {31'h0000_0000, err});
        wr_cfg(spd_pkg::IDX_B0, 24'hF1_0004);
        shape_chk(1'b1, 6, 12);
        apb_xfer(1'b0, spd_pkg::IDX_STATUS, 32'h0000_0000, rd, err);
        check("B kind low frequency", 32'h0000_0001, {30'h0000_0000, rd[3:2]});
        for (int i = 0; i < 5; i++) begin
            wr_cfg(spd_pkg::IDX_B0, FRM_CFG[i]);
            shape_chk(1'b1, FRM_HI[i], FRM_PER[i]);
        end
        apb_xfer(1'b0, spd_pkg::IDX_STATUS, 32'h0000_0000, rd, err);
        check("B kind frame", 32'h0000_0002, {30'h0000_0000, rd[3:2]});
        wr_cfg(spd_pkg::IDX_A0, 24'hF0_0006);
        shape_chk(1'b0, 9, 18);
        apb_xfer(1'b0, spd_pkg::IDX_STATUS, 32'h0000_0000, rd, err);
        check("A kind low frequency", 32'h0000_0001, {30'h0000_0000, rd[1:0]});
        wr_cfg(spd_pkg::IDX_B0, 24'h00_0004);
        wr_cfg(spd_pkg::IDX_A0, 24'hF9_0003);
        shape_chk(1'b0, 4, 12);
        rd_chk("A staged byte 2", spd_pkg::IDX_A0 + 8'h02, 32'h0000_00F9);
        wr_cfg(spd_pkg::IDX_A0, 24'hF3_0002);
        shape_chk(1'b0, 6, 12);
        wr_cfg(spd_pkg::IDX_B0, 24'h00_0001);
        shape_chk(1'b1, 1, 2);
        finish_test();
    end
endmodule // spd_post_divider_framer_tb
